// File: inc/apll_defines.vh
`ifndef APLL_CFG_DEFINES_VH
`define APLL_CFG_DEFINES_VH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define ACR_ADDR_W 12
`define ACR_A_DIVEN 12'h100
`define ACR_A_RATIO 12'h101
`define ACR_A_INSEL 12'h102
`define ACR_A_PHASE 12'h103
`define ACR_A_FB0 12'h106
`define ACR_A_FB1 12'h107
`define ACR_A_FB2 12'h108
`define ACR_A_FB3 12'h109
`define ACR_A_FB4 12'h10A
`define ACR_A_FB5 12'h10B
// ----------------------------------------
// reset values
// ----------------------------------------
`define ACR_RST_BYTE 8'h00
`define ACR_RST_FB5 2'h0
// ----------------------------------------
// field positions
// ----------------------------------------
`define ACR_EN2_BIT 2
`define ACR_BYP_BIT 1
`define ACR_DIV2_HI 7
`define ACR_DIV2_LO 4
`define ACR_DIV1_HI 3
`define ACR_DIV1_LO 0
`define ACR_PIN_SOURCE_SWITCH_MODE_BIT 6
`define ACR_ALT_HI 5
`define ACR_ALT_LO 3
`define ACR_PRI_HI 2
`define ACR_PRI_LO 0
`define ACR_DN_BIT 7
`define ACR_DNS_HI 6
`define ACR_DNS_LO 4
`define ACR_UP_BIT 3
`define ACR_UPS_HI 2
`define ACR_UPS_LO 0
`define ACR_FB5_HI 1
`define ACR_FB_W 42
`define ACR_FB_FRAC 33
// ----------------------------------------
// source codes
// ----------------------------------------
`define ACR_SRC_XTAL 3'h0
`define ACR_SRC_IC1 3'h1
`define ACR_SRC_IC2 3'h2
`define ACR_SRC_IC3 3'h3
`define ACR_SRC_D_IC1 3'h4
`define ACR_SRC_D_NONE1 3'h5
`define ACR_SRC_D_XTAL 3'h6
`define ACR_SRC_D_NONE 3'h7
`define ACR_PS_BIT 3'h0
`define ACR_PS_GPIO0 3'h1
`define ACR_PS_GPIO3 3'h4
// one-hot source outputs: bit0 xtal, 1..3 clocks, 4 dpll
`define ACR_OH_NONE 5'h00
`define ACR_OH_XTAL 5'h01
`define ACR_OH_IC1 5'h02
`define ACR_OH_IC2 5'h04
`define ACR_OH_IC3 5'h08
`define ACR_OH_DPLL 5'h10
`endif

// File: design/apll_edge_step.v
`timescale 1ns/1ps
`include "apll_defines.vh"
// two-stage synchroniser plus both-edge detector for one step source
module apll_edge_step
(
  input wire I_CLK,
  input wire I_RST,
  input wire [3:0] i_gpio,
  input wire i_reg_bit,
  input wire [2:0] i_source,
  output reg o_step
);
  reg [3:0] sync_a; // first stage, read only by sync_b
  reg [3:0] sync_b; // second stage
  reg level; // selected source, registered
  reg level_d; // last cycle's level
  reg next_level; // selected source this cycle

  // ----------------------------------------
  // synchroniser
  // ----------------------------------------
  // gpio pins pass two flops before any logic sees them
  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end
    else
    begin
      sync_a <= i_gpio;
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------
  // source select
  // ----------------------------------------
  always @*
  begin
    next_level = 1'b0;
    case (i_source)
      `ACR_PS_BIT: next_level = i_reg_bit;
      3'h1: next_level = sync_b[0];
      3'h2: next_level = sync_b[1];
      3'h3: next_level = sync_b[2];
      `ACR_PS_GPIO3: next_level = sync_b[3];
      default: next_level = 1'b0; // unused codes hold still
    endcase
  end

  // ----------------------------------------
  // edge detect
  // ----------------------------------------
  // every rise and every fall gives one pulse
  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      level <= 1'b0;
      level_d <= 1'b0;
      o_step <= 1'b0;
    end
    else
    begin
      level <= next_level;
      level_d <= level;
      o_step <= level ^ level_d;
    end
  end
endmodule

// File: design/apll_config_regs.v
`timescale 1ns/1ps
`include "apll_defines.vh"
// Summary of operation
// - divider two runs when enabled, not bypassed and the analog loop is enabled
// - bypass bit steers mux after divider two
// - divider two code gives ratio table
// - divider one uses the same ratio table
// - pin switch picks primary or alternate field
// - alternate field ignored without pin switching
// - alternate codes select crystal or clocks
// - primary top bit zero feeds pin directly
// - codes one to three route clock everywhere
// - codes six, seven feed dpll to loop
// - codes four, five for clock-one masters
// - decrement source from bits six to four
// - each source edge steps phase earlier
// - increment source from bits two to zero
// - each source edge steps phase later
// - register step bits apply for code zero
// - feedback term is 42-bit fixed point
module apll_config_regs
(
  input wire I_CLK,
  input wire I_RST,
  input wire [11:0] i_addr,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  output reg o_rvalid,
  input wire i_analog_loop_enable,
  input wire [3:0] i_gpio,
  input wire [1:0] i_switch_pin_select,
  output reg o_fast_div_two_on,
  output reg o_loop_skip_select,
  output reg [4:0] o_div_two_half,
  output reg [4:0] o_div_one_half,
  output reg [4:0] o_loop_source,
  output reg [4:0] o_skip_source,
  output reg o_dpll_needed,
  output reg [2:0] o_active_select,
  output wire o_phase_down_step,
  output wire o_phase_up_step,
  output reg [41:0] o_feedback_fixed_term
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [7:0] reg_diven; // divider enable and bypass
  reg [7:0] reg_ratio; // divider ratio codes
  reg [7:0] reg_insel; // input source select
  reg [7:0] reg_phase; // phase step control
  reg [7:0] fb0; // term bits 7..0
  reg [7:0] fb1; // term bits 15..8
  reg [7:0] fb2; // term bits 23..16
  reg [7:0] fb3; // term bits 31..24
  reg [7:0] fb4; // term bits 39..32
  reg [1:0] fb5; // term bits 41..40
  reg [7:0] next_rdata; // read mux result
  reg [2:0] next_select; // effective source code
  reg next_pin; // selected switching pin
  reg [4:0] next_loop; // loop source one-hot
  reg [4:0] next_skip; // bypass source one-hot
  reg next_dpll; // dpll feeds the loop

  // ratio code to ratio in half units, 4.0 -> 8
  function [4:0] ratio_half;
    input [3:0] code;
    begin
      if (code[3])
        ratio_half = {code, 1'b0}; // integer 8..15
      else
        ratio_half = {2'b00, code[2:0]} + 5'h08; // 4..7.5
    end
  endfunction

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // byte writes at the printed addresses
  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      reg_diven <= `ACR_RST_BYTE;
      reg_ratio <= `ACR_RST_BYTE;
      reg_insel <= `ACR_RST_BYTE;
      reg_phase <= `ACR_RST_BYTE;
      fb0 <= `ACR_RST_BYTE;
      fb1 <= `ACR_RST_BYTE;
      fb2 <= `ACR_RST_BYTE;
      fb3 <= `ACR_RST_BYTE;
      fb4 <= `ACR_RST_BYTE;
      fb5 <= `ACR_RST_FB5;
    end
    else if (i_wr)
    begin
      case (i_addr)
        // only the two defined bits are kept
        `ACR_A_DIVEN: reg_diven <= i_wdata & 8'h06;
        `ACR_A_RATIO: reg_ratio <= i_wdata;
        // bit 7 reserved
        `ACR_A_INSEL: reg_insel <= i_wdata & 8'h7F;
        `ACR_A_PHASE: reg_phase <= i_wdata;
        `ACR_A_FB0: fb0 <= i_wdata;
        `ACR_A_FB1: fb1 <= i_wdata;
        `ACR_A_FB2: fb2 <= i_wdata;
        `ACR_A_FB3: fb3 <= i_wdata;
        `ACR_A_FB4: fb4 <= i_wdata;
        `ACR_A_FB5: fb5 <= i_wdata[`ACR_FB5_HI:0];
        default: ; // unmapped writes are dropped
      endcase
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always @*
  begin
    next_rdata = 8'h00;
    case (i_addr)
      `ACR_A_DIVEN: next_rdata = reg_diven;
      `ACR_A_RATIO: next_rdata = reg_ratio;
      `ACR_A_INSEL: next_rdata = reg_insel;
      `ACR_A_PHASE: next_rdata = reg_phase;
      `ACR_A_FB0: next_rdata = fb0;
      `ACR_A_FB1: next_rdata = fb1;
      `ACR_A_FB2: next_rdata = fb2;
      `ACR_A_FB3: next_rdata = fb3;
      `ACR_A_FB4: next_rdata = fb4;
      `ACR_A_FB5: next_rdata = {6'h00, fb5};
      default: next_rdata = 8'h00; // unmapped reads zero
    endcase
  end

  // read data registered one cycle after the strobe
  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= i_rd;
      if (i_rd)
        o_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // source selection
  // ----------------------------------------
  always @*
  begin
    next_pin = i_gpio[i_switch_pin_select];
    // alternate field only counts in switching mode with pin high
    if (reg_insel[`ACR_PIN_SOURCE_SWITCH_MODE_BIT] && next_pin)
      next_select = reg_insel[`ACR_ALT_HI:`ACR_ALT_LO];
    else
      next_select = reg_insel[`ACR_PRI_HI:`ACR_PRI_LO];
    next_loop = `ACR_OH_NONE;
    next_skip = `ACR_OH_NONE;
    next_dpll = 1'b0;
    case (next_select)
      // top bit zero: pin straight to loop, dpll may sleep
      `ACR_SRC_XTAL:
      begin
        next_loop = `ACR_OH_XTAL;
        next_skip = `ACR_OH_XTAL;
      end
      `ACR_SRC_IC1:
      begin
        next_loop = `ACR_OH_IC1;
        next_skip = `ACR_OH_IC1;
      end
      `ACR_SRC_IC2:
      begin
        next_loop = `ACR_OH_IC2;
        next_skip = `ACR_OH_IC2;
      end
      `ACR_SRC_IC3:
      begin
        next_loop = `ACR_OH_IC3;
        next_skip = `ACR_OH_IC3;
      end
      `ACR_SRC_D_IC1:
      begin
        next_loop = `ACR_OH_DPLL;
        next_skip = `ACR_OH_IC1;
        next_dpll = 1'b1;
      end
      `ACR_SRC_D_NONE1:
      begin
        next_loop = `ACR_OH_DPLL;
        next_dpll = 1'b1;
      end
      `ACR_SRC_D_XTAL:
      begin
        next_loop = `ACR_OH_DPLL;
        next_skip = `ACR_OH_XTAL;
        next_dpll = 1'b1;
      end
      `ACR_SRC_D_NONE:
      begin
        next_loop = `ACR_OH_DPLL;
        next_dpll = 1'b1;
      end
      default:
      begin
        next_loop = `ACR_OH_NONE;
        next_skip = `ACR_OH_NONE;
      end
    endcase
    // alternate codes 4..7 are unused: nothing selected
    if (reg_insel[`ACR_PIN_SOURCE_SWITCH_MODE_BIT] && next_pin && next_select[2])
    begin
      next_loop = `ACR_OH_NONE;
      next_skip = `ACR_OH_NONE;
      next_dpll = 1'b0;
    end
  end

  // ----------------------------------------
  // registered control outputs
  // ----------------------------------------
  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      o_fast_div_two_on <= 1'b0;
      o_loop_skip_select <= 1'b0;
      o_div_two_half <= 5'h08;
      o_div_one_half <= 5'h08;
      o_loop_source <= `ACR_OH_NONE;
      o_skip_source <= `ACR_OH_NONE;
      o_dpll_needed <= 1'b0;
      o_active_select <= 3'h0;
      o_feedback_fixed_term <= 42'h0;
    end
    else
    begin
      o_fast_div_two_on <= i_analog_loop_enable &
        reg_diven[`ACR_EN2_BIT] & ~reg_diven[`ACR_BYP_BIT];
      o_loop_skip_select <= reg_diven[`ACR_BYP_BIT];
      o_div_two_half <=
        ratio_half(reg_ratio[`ACR_DIV2_HI:`ACR_DIV2_LO]);
      o_div_one_half <=
        ratio_half(reg_ratio[`ACR_DIV1_HI:`ACR_DIV1_LO]);
      o_loop_source <= next_loop;
      o_skip_source <= next_skip;
      o_dpll_needed <= next_dpll;
      o_active_select <= next_select;
      // 9 integer bits over 33 fraction bits
      o_feedback_fixed_term <= {fb5, fb4, fb3, fb2, fb1, fb0};
    end
  end

  // ----------------------------------------
  // phase steps
  // ----------------------------------------
  apll_edge_step u_down
  (
    .I_CLK(I_CLK),
    .I_RST(I_RST),
    .i_gpio(i_gpio),
    .i_reg_bit(reg_phase[`ACR_DN_BIT]),
    .i_source(reg_phase[`ACR_DNS_HI:`ACR_DNS_LO]),
    .o_step(o_phase_down_step)
  );

  apll_edge_step u_up
  (
    .I_CLK(I_CLK),
    .I_RST(I_RST),
    .i_gpio(i_gpio),
    .i_reg_bit(reg_phase[`ACR_UP_BIT]),
    .i_source(reg_phase[`ACR_UPS_HI:`ACR_UPS_LO]),
    .o_step(o_phase_up_step)
  );
endmodule

// File: test/acr_host.sv
`timescale 1ns/1ps
// host software side: byte writes and reads on the register port
module acr_host
(
  input wire logic I_CLK,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output logic [11:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  // idle port at time zero
  initial
  begin
    o_addr = 12'h000;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // one write strobe; callers may set spare bits, the register drops them
  // returns once the registered controls show the new value
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge I_CLK);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge I_CLK);
    o_wr = 1'b0;
    o_wdata = ~d;
    @(negedge I_CLK);
  endtask
  // one read strobe, answer taken half a cycle after the read edge
  task automatic rd(input logic [11:0] a, output logic [7:0] d,
                    output logic v);
    @(negedge I_CLK);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge I_CLK);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
    v = i_rvalid;
  endtask
endmodule

// File: test/acr_asserts.sv
`timescale 1ns/1ps
`include "apll_defines.vh"
// watches the register port and the decoded controls
module acr_checker
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [11:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic o_rvalid,
  input wire logic o_fast_div_two_on,
  input wire logic o_loop_skip_select,
  input wire logic [4:0] o_div_two_half,
  input wire logic [4:0] o_div_one_half,
  input wire logic [4:0] o_loop_source,
  input wire logic o_dpll_needed,
  input wire logic [2:0] o_active_select,
  input wire logic o_phase_down_step,
  input wire logic [41:0] o_feedback_fixed_term
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  // ratio times two for a 4-bit divider code
  function automatic logic [4:0] half(input logic [3:0] c);
    half = c[3] ? {c, 1'b0} : {2'b01, c[2:0]};
  endfunction
  wire w_ratio = i_wr && i_addr == `ACR_A_RATIO;
  wire w_sel = i_wr && i_addr == `ACR_A_INSEL;
  AST_RVALID: assert property (1'b1 |=> o_rvalid == $past(i_rd))
    else $error("read answer not one cycle after request");
  // register stored at the write edge, controls one edge later
  AST_DIV_ON: assert property (o_fast_div_two_on |->
    !o_loop_skip_select)
    else $error("divider two on while bypassed");
  AST_BYPASS: assert property (i_wr && i_addr == `ACR_A_DIVEN |->
    ##2 o_loop_skip_select == $past(i_wdata[1], 2))
    else $error("bypass select not taken from write");
  AST_DIV_TWO: assert property (w_ratio |->
    ##2 o_div_two_half == half($past(i_wdata[7:4], 2)))
    else $error("divider two ratio wrong");
  AST_DIV_ONE: assert property (w_ratio |->
    ##2 o_div_one_half == half($past(i_wdata[3:0], 2)))
    else $error("divider one ratio wrong");
  AST_NO_SWITCH: assert property (w_sel && !i_wdata[6] |->
    ##2 o_active_select == $past(i_wdata[2:0], 2))
    else $error("alternate field used without switching");
  AST_ONE_SRC: assert property ($onehot0(o_loop_source))
    else $error("more than one loop source");
  AST_PIN_FEED: assert property (!o_active_select[2] |-> !o_dpll_needed)
    else $error("dpll used for a direct pin code");
  AST_DPLL: assert property (o_dpll_needed ==
    (o_loop_source == `ACR_OH_DPLL))
    else $error("dpll flag and loop source disagree");
  AST_TERM: assert property (i_wr && i_addr == `ACR_A_FB0 |->
    ##2 o_feedback_fixed_term[7:0] == $past(i_wdata, 2))
    else $error("feedback term low byte wrong");
  cover property (w_ratio ##2 o_div_two_half == 5'h1E);
  cover property (o_phase_down_step);
  cover property (o_dpll_needed);
endmodule
bind apll_config_regs acr_checker chk (.*);

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int RUN_CYCLES = 2000; // well above the expected run
  logic I_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic en = 1'b0;
  logic [3:0] gpio = 4'h0;
  logic [1:0] psel = 2'h2; // pin two steers switching
  wire [11:0] addr;
  wire [7:0] wdata, rdata;
  wire wr, rd, rvalid, f2on, skip, dpll, dn, up;
  wire [4:0] h2, h1, lsrc, ssrc;
  wire [2:0] asel;
  wire [41:0] term;
  logic [7:0] q;
  logic v;
  int mismatches = 0;
  int total_checks = 0;
  int dn_cnt = 0;
  int up_cnt = 0;
  // address, write data, read-back value
  logic [27:0] rows [12] = '{28'h100FF06, 28'h101A5A5, 28'h102FF7F,
    28'h1037777, 28'h1061111, 28'h1072222, 28'h1083333, 28'h1094444,
    28'h10A5555, 28'h10BFF03, 28'h104FF00, 28'h10CFF00};
  logic [4:0] loop_exp [8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h10,
    5'h10, 5'h10};
  logic [4:0] skip_exp [8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h02, 5'h00,
    5'h01, 5'h00};
  always #50 I_CLK = ~I_CLK;
  acr_host host (.I_CLK(I_CLK), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  apll_config_regs dut (.I_CLK(I_CLK), .I_RST(I_RST), .i_addr(addr),
    .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata),
    .o_rvalid(rvalid), .i_analog_loop_enable(en), .i_gpio(gpio),
    .i_switch_pin_select(psel), .o_fast_div_two_on(f2on),
    .o_loop_skip_select(skip), .o_div_two_half(h2), .o_div_one_half(h1),
    .o_loop_source(lsrc), .o_skip_source(ssrc), .o_dpll_needed(dpll),
    .o_active_select(asel), .o_phase_down_step(dn),
    .o_phase_up_step(up), .o_feedback_fixed_term(term));
  // count phase step pulses
  always @(posedge I_CLK)
  begin
    if (dn === 1'b1)
      dn_cnt++;
    if (up === 1'b1)
      up_cnt++;
  end
  task automatic chk(input string n, input logic [41:0] e,
                     input logic [41:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // settle, compare both step counts, clear them
  task automatic steps(input int e);
    repeat (6) @(negedge I_CLK);
    chk("down steps", 42'(e), 42'(dn_cnt));
    chk("up steps", 42'(e), 42'(up_cnt));
    dn_cnt = 0;
    up_cnt = 0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #(RUN_CYCLES * 100);
    mismatches++;
    summarize();
  end
  initial
  begin
    repeat (12) @(negedge I_CLK);
    I_RST = 1'b0;
    chk("div two reset", 42'h08, 42'(h2));
    chk("div one reset", 42'h08, 42'(h1));
    for (int i = 0; i < 12; i++)
    begin
      host.rd(rows[i][27:16], q, v);
      chk("reset value", 42'h00, 42'(q));
      host.wr(rows[i][27:16], rows[i][15:8]);
      host.rd(rows[i][27:16], q, v);
      chk("read valid", 42'h1, 42'(v));
      chk("read data", 42'(rows[i][7:0]), 42'(q));
    end
    chk("term", 42'h35544332211, term);
    $display("test registers done");
    for (int c = 0; c < 16; c++)
    begin
      host.wr(12'h101, 8'(c * 17));
      chk("div two", 42'(c < 8 ? c + 8 : 2 * c), 42'(h2));
      chk("div one", 42'(c < 8 ? c + 8 : 2 * c), 42'(h1));
    end
    for (int i = 0; i < 8; i++)
    begin
      en = i[2];
      host.wr(12'h100, 8'(i * 2) ^ 8'hF8);
      chk("div two on", 42'(i[2] & i[1] & ~i[0]), 42'(f2on));
      chk("bypass", 42'(i[0]), 42'(skip));
    end
    $display("test dividers done");
    gpio = 4'hF;
    for (int c = 0; c < 8; c++)
    begin
      host.wr(12'h102, 8'(c) | 8'(7 - c) << 3);
      chk("loop source", 42'(loop_exp[c]), 42'(lsrc));
      chk("skip source", 42'(skip_exp[c]), 42'(ssrc));
      chk("dpll needed", 42'(c / 4), 42'(dpll));
    end
    for (int a = 0; a < 8; a++)
    begin
      gpio = 4'h0;
      host.wr(12'h102, 8'h46 | 8'(a) << 3);
      chk("primary pick", 42'h10, 42'(lsrc));
      gpio = 4'h4;
      @(negedge I_CLK);
      chk("alternate pick", 42'(a < 4 ? loop_exp[a] : 5'h00), 42'(lsrc));
    end
    $display("test source select done");
    gpio = 4'h0;
    host.wr(12'h103, 8'h00);
    repeat (6) @(negedge I_CLK);
    dn_cnt = 0;
    up_cnt = 0;
    host.wr(12'h103, 8'h88);
    steps(1);
    host.wr(12'h103, 8'h00);
    steps(1);
    for (int k = 1; k < 5; k++)
    begin
      host.wr(12'h103, 8'(k * 17));
      steps(0);
      host.wr(12'h103, 8'(k * 17) | 8'h88);
      steps(0);
      gpio = 4'hF ^ (4'h1 << (k - 1));
      steps(0);
      gpio = 4'hF;
      steps(1);
      gpio = 4'h0;
      steps(1);
    end
    host.wr(12'h103, 8'h55);
    gpio = 4'hF;
    steps(0);
    $display("test phase steps done");
    summarize();
  end
endmodule
